/* rtl/csdr_pkg.sv */
/*
 Package for the clock synthesis, divide and route block.
 Assumes one 25 MHz clock and an APB register bus.
*/
package csdr_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'H00;
    localparam logic [7:0] OFS_SYNTH = 8'H04;
    localparam logic [7:0] OFS_OUTD0 = 8'H08;
    localparam logic [7:0] OFS_OUTD5 = 8'H1C;
    localparam logic [7:0] OFS_PDIV = 8'H20;
    localparam logic [7:0] OFS_EDIV = 8'H24;
    localparam logic [7:0] OFS_ENET = 8'H28;
    localparam logic [7:0] OFS_TSEL = 8'H2C;
    localparam logic [7:0] OFS_TGATE = 8'H30;
    localparam logic [7:0] OFS_STAT = 8'H34;
    // ==========================================
    // Reset values
    localparam logic [3:0] RST_CTRL = 4'HC;
    localparam logic [6:0] RST_DIV = 7'H00;
    // ==========================================
    // Counts and sizes
    localparam int N_OUT = 6;
    localparam int N_TRUNK = 16;
    localparam int N_SRC = 64;
    localparam int N_FAB = 56;
    localparam int N_ENET = 4;
    localparam int N_ESRC = 9;
    localparam int SYNC_W = 66;
    localparam logic [3:0] LOCK_PERIODS = 4'H8;
    // Source positions in the center source vector.
    localparam int SRC_SWITCH = 6;
    localparam int SRC_BOTTOM_MID_SELECTOR = 7;
    localparam int SRC_FAB = 8;
    // Edge divider modes.
    typedef enum logic [1:0] {EDIV_2, EDIV_3P5, EDIV_4, EDIV_5} csdr_emode_t;
    // Glitchless switch states.
    typedef enum logic [1:0] {SW_IDLE, SW_DROP, SW_PICK} csdr_sw_t;
    // Run-time phase controls from fabric.
    typedef struct packed {
        logic [2:0] phase_output_chooser;
        logic sense;
        logic phase_rotate_strobe;
        logic phase_load_strobe;
    } csdr_phase_ctl_t;
endpackage

/* rtl/csdr_top.sv */
/*
 Clock synthesizer model, primary and edge dividers, edge nets and the
 center selector with glitchless switch and gating, all on ref_clk.
 Assumes an APB master on ref_clk; pin clocks are asynchronous levels.
*/
// Local design decisions: the APB slave port and the placing of the registers.
// Function
// - six outputs, each divided 1 to 128
// - reference passes an input divider
// - feedback divider sets multiplication, selectable path
// - each output drives primary or edge nets
// - programmable phase offset, static or dynamic
// - chooser, sense, rotate, load step phase
// - lock raised on lock, dropped on loss
// - primary divider ratios 1 to 128
// - primary divider feeds switch input
// - divider reset forces outputs low asynchronously
// - divider toggles cycle after reset release
// - edge divider 2, 3.5, 4, 5 deterministic
// - edge divider input is selectable
// - edge divider feeds bottom mid selector
// - 64 sources onto 16 trunks
// - two inputs routed through the switch
// - glitchless gating and two-clock selection
// - sixteen clocks per primary domain
// - four edge nets per bottom bank
// - edge net sources: pin, delayed, synth, internal
// - disabled net static, no added latency
`timescale 1ns/1ps
module csdr_top (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous pins and fabric clocks.
    input wire csdr_pkg::csdr_phase_ctl_t phase_ctl,
    input wire logic pin_clk,
    input wire logic pin_clk_dly,
    input wire logic int_node,
    input wire logic fb_route,
    input wire logic [csdr_pkg::N_FAB-1:0] fabric_clk,
    // Clock outputs.
    output logic [csdr_pkg::N_OUT-1:0] synth_out,
    output logic synth_lock,
    output logic pdiv_out,
    output logic ediv_out,
    output logic [csdr_pkg::N_ENET-1:0] edge_net,
    output logic [csdr_pkg::N_TRUNK-1:0] trunk
);
    import csdr_pkg::*;

    // ==========================================
    // Input synchronisers
    logic [SYNC_W-1:0] sync1_r; // First stage, read only by sync2_r.
    logic [SYNC_W-1:0] sync2_r; // Safe copies of all pins.
    logic [1:0] strobe_prev_r; // Previous rotate and load levels.

    // Two flops on every pin before any logic reads it.
    always_ff @(posedge ref_clk) begin
        sync1_r <= {phase_ctl, pin_clk, pin_clk_dly, int_node, fb_route,
            fabric_clk};
        sync2_r <= sync1_r;
    end

    wire csdr_phase_ctl_t ph_s = sync2_r[65:60];
    wire pin_s = sync2_r[59];
    wire dly_s = sync2_r[58];
    wire node_s = sync2_r[57];
    wire fbr_s = sync2_r[56];
    wire [N_FAB-1:0] fab_s = sync2_r[N_FAB-1:0];
    wire rot_p = ph_s.phase_rotate_strobe & ~strobe_prev_r[1];
    wire load_p = ph_s.phase_load_strobe & ~strobe_prev_r[0];

    // ==========================================
    // Registers
    logic [3:0] ctrl_r; // En, feedback from routing, two divider resets.
    logic [6:0] ref_lim_r; // Input divider ratio minus one.
    logic [6:0] fb_lim_r; // Feedback divider ratio minus one.
    logic [6:0] out_lim_r [N_OUT]; // Output divider ratios minus one.
    logic [6:0] out_ph_r [N_OUT]; // Static phase offsets.
    logic [N_OUT-1:0] out_edge_r; // High routes output to edge nets.
    logic [2:0] pdiv_code_r; // Primary divider ratio as power of two.
    logic [5:0] feed_a_r; // Feeder in front of the primary divider.
    logic [5:0] feed_b_r; // Feeder on the second switch input.
    logic sw_want_r; // Requested switch input.
    csdr_emode_t emode_r; // Edge divider mode.
    logic [3:0] esrc_r; // Edge divider input select.
    logic [3:0] enet_sel_r [N_ENET]; // Edge net source selects.
    logic [5:0] tsel_r [N_TRUNK]; // Center selector per trunk.
    logic [3:0] tidx_r; // Trunk shown on readback.
    logic [N_TRUNK-1:0] tgate_r; // Requested trunk enables.

    wire synth_en = ctrl_r[0];
    wire pdiv_rst = ctrl_r[2];
    wire ediv_rst = ctrl_r[3];

    // ==========================================
    // APB decode
    wire acc = psel & ~penable; // Setup phase: answer follows next edge.
    wire wr = psel & penable & pready & pwrite;
    wire [2:0] oidx = 3'((paddr - OFS_OUTD0) >> 2);
    wire is_out = paddr >= OFS_OUTD0 && paddr <= OFS_OUTD5 &&
        paddr[1:0] == 2'H0;
    wire hit = is_out || paddr == OFS_CTRL || paddr == OFS_SYNTH ||
        paddr == OFS_PDIV || paddr == OFS_EDIV || paddr == OFS_ENET ||
        paddr == OFS_TSEL || paddr == OFS_TGATE || paddr == OFS_STAT;
    wire cfg_wr = wr && (paddr == OFS_SYNTH || paddr == OFS_CTRL || is_out);

    // Software writes; a loop covers the repeated fields.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_r <= RST_CTRL;
            ref_lim_r <= RST_DIV;
            fb_lim_r <= RST_DIV;
            out_edge_r <= '0;
            pdiv_code_r <= 3'H0;
            feed_a_r <= 6'H00;
            feed_b_r <= 6'H00;
            sw_want_r <= 1'b0;
            emode_r <= EDIV_2;
            esrc_r <= 4'H0;
            tidx_r <= 4'H0;
            tgate_r <= '0;
            for (int i = 0; i < N_OUT; i++) begin
                out_lim_r[i] <= RST_DIV;
                out_ph_r[i] <= RST_DIV;
            end
            for (int i = 0; i < N_ENET; i++) begin
                enet_sel_r[i] <= 4'H0;
            end
            for (int i = 0; i < N_TRUNK; i++) begin
                tsel_r[i] <= 6'H00;
            end
        end else if (wr) begin
            if (paddr == OFS_CTRL) begin
                ctrl_r <= pwdata[3:0];
            end
            if (paddr == OFS_SYNTH) begin
                ref_lim_r <= pwdata[6:0];
                fb_lim_r <= pwdata[14:8];
            end
            if (is_out && oidx < 3'(N_OUT)) begin
                out_lim_r[oidx] <= pwdata[6:0];
                out_ph_r[oidx] <= pwdata[14:8];
                out_edge_r[oidx] <= pwdata[16];
            end
            if (paddr == OFS_PDIV) begin
                pdiv_code_r <= pwdata[2:0];
                feed_a_r <= pwdata[13:8];
                feed_b_r <= pwdata[21:16];
                sw_want_r <= pwdata[24];
            end
            if (paddr == OFS_EDIV) begin
                emode_r <= csdr_emode_t'(pwdata[1:0]);
                esrc_r <= pwdata[7:4];
            end
            if (paddr == OFS_ENET) begin
                for (int i = 0; i < N_ENET; i++) begin
                    enet_sel_r[i] <= pwdata[4*i +: 4];
                end
            end
            if (paddr == OFS_TSEL) begin
                tidx_r <= pwdata[11:8];
                tsel_r[pwdata[11:8]] <= pwdata[5:0];
            end
            if (paddr == OFS_TGATE) begin
                tgate_r <= pwdata[N_TRUNK-1:0];
            end
        end
    end

    // ==========================================
    // Synthesizer loop and lock
    logic [6:0] ref_cnt_r; // Input divider count.
    logic [6:0] fb_cnt_r; // Feedback divider count.
    logic [1:0] per_fb_r; // Feedback ticks in this reference period.
    logic [3:0] good_r; // Consecutive matching periods.
    logic fb_prev_r; // Last feedback level, for edge detection.
    logic [6:0] cnt_r [N_OUT]; // Output divider counts.

    function automatic logic [6:0] step(input logic [6:0] c,
            input logic [6:0] l);
        return (c >= l) ? 7'H00 : c + 7'H01;
    endfunction

    // Feedback comes from the main output or from routing.
    wire fb_lvl = ctrl_r[1] ? fbr_s : synth_out[0];
    wire fb_edge = fb_lvl & ~fb_prev_r;
    wire ref_tick = ref_cnt_r == ref_lim_r;
    wire fb_tick = fb_edge && fb_cnt_r == fb_lim_r;
    wire [1:0] per_inc = (per_fb_r == 2'H3) ? per_fb_r :
        per_fb_r + {1'b0, fb_tick};

    // Lock holds while exactly one feedback tick lands per reference
    // period; a config write restarts the search because the ratio moved.
    always_ff @(posedge ref_clk) begin
        if (!rstn || !synth_en || cfg_wr) begin
            ref_cnt_r <= 7'H00;
            fb_cnt_r <= 7'H00;
            per_fb_r <= 2'H0;
            good_r <= 4'H0;
            synth_lock <= 1'b0;
            fb_prev_r <= 1'b0;
        end else begin
            fb_prev_r <= fb_lvl;
            ref_cnt_r <= step(ref_cnt_r, ref_lim_r);
            if (fb_edge) begin
                fb_cnt_r <= step(fb_cnt_r, fb_lim_r);
            end
            if (ref_tick) begin
                per_fb_r <= 2'H0;
                if (per_inc == 2'H1 && good_r != LOCK_PERIODS) begin
                    good_r <= good_r + 4'H1;
                end else if (per_inc != 2'H1) begin
                    good_r <= 4'H0;
                    synth_lock <= 1'b0;
                end
                if (per_inc == 2'H1 && good_r >= LOCK_PERIODS - 4'H1) begin
                    synth_lock <= 1'b1;
                end
            end else begin
                per_fb_r <= per_inc;
            end
        end
    end

    // Output dividers with phase load and rotate per chosen output.
    for (genvar k = 0; k < N_OUT; k++) begin : g_out
        wire pick = ph_s.phase_output_chooser == 3'(k);
        wire [7:0] half = ({1'b0, out_lim_r[k]} + 8'H01) >> 1;
        always_ff @(posedge ref_clk) begin
            if (!rstn || !synth_en) begin
                cnt_r[k] <= 7'H00;
                synth_out[k] <= 1'b0;
            end else begin
                if (load_p && pick) begin
                    cnt_r[k] <= out_ph_r[k];
                end else if (rot_p && pick && ph_s.sense) begin
                    cnt_r[k] <= step(step(cnt_r[k], out_lim_r[k]),
                        out_lim_r[k]);
                end else if (!(rot_p && pick)) begin
                    cnt_r[k] <= step(cnt_r[k], out_lim_r[k]);
                end
                synth_out[k] <= cnt_r[k] >= half[6:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            strobe_prev_r <= 2'H0;
        end else begin
            strobe_prev_r <= {ph_s.phase_rotate_strobe, ph_s.phase_load_strobe};
        end
    end

    // ==========================================
    // Source vectors
    wire [N_OUT-1:0] to_edge = synth_out & out_edge_r;
    wire [N_OUT-1:0] to_prim = synth_out & ~out_edge_r;
    wire [N_ESRC-1:0] esrc_v = {node_s, to_edge, dly_s, pin_s};
    logic sw_out_r; // Glitchless switch output.
    wire [N_SRC-1:0] src_v = {fab_s, ediv_out, sw_out_r, to_prim};

    // ==========================================
    // Edge nets and edge divider
    // Four nets for the bottom bank, each a registered selection.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            edge_net <= '0;
        end else begin
            for (int i = 0; i < N_ENET; i++) begin
                edge_net[i] <= enet_sel_r[i] < 4'(N_ESRC) &&
                    esrc_v[enet_sel_r[i]];
            end
        end
    end

    logic ein_prev_r; // Last edge divider input level.
    logic [2:0] ecnt_r; // Edge divider count.
    wire ein = esrc_r < 4'(N_ESRC) && esrc_v[esrc_r];
    wire ein_edge = ein & ~ein_prev_r;
    wire [2:0] elim = (emode_r == EDIV_2) ? 3'H1 :
        (emode_r == EDIV_4) ? 3'H3 : (emode_r == EDIV_5) ? 3'H4 : 3'H6;
    // In 3.5 mode rises at counts 0 and 3: periods of three then four.
    wire ehigh = (emode_r == EDIV_3P5) ?
        (ecnt_r == 3'H0 || ecnt_r == 3'H1 || ecnt_r == 3'H3 ||
        ecnt_r == 3'H4) : ({1'b0, ecnt_r} < ({1'b0, elim} + 4'H1) >> 1);

    // Counting from zero at release fixes the phase to the fast clock.
    always_ff @(posedge ref_clk or posedge ediv_rst) begin
        if (ediv_rst) begin
            ecnt_r <= 3'H0;
            ein_prev_r <= 1'b0;
            ediv_out <= 1'b0;
        end else begin
            ein_prev_r <= ein;
            if (ein_edge) begin
                ecnt_r <= (ecnt_r >= elim) ? 3'H0 : ecnt_r + 3'H1;
                ediv_out <= ehigh;
            end
        end
    end

    // ==========================================
    // Primary divider
    logic pin_prev_r; // Last primary divider input level.
    logic [6:0] pcnt_r; // Free count of input rising edges.
    wire pin_lvl = src_v[feed_a_r];
    wire pin_edge = pin_lvl & ~pin_prev_r;
    wire [6:0] pcnt_nxt = pcnt_r + 7'H01;

    // Output is a count bit, or the input itself in bypass.
    always_ff @(posedge ref_clk or posedge pdiv_rst) begin
        if (pdiv_rst) begin
            pcnt_r <= 7'H00;
            pin_prev_r <= 1'b0;
            pdiv_out <= 1'b0;
        end else begin
            pin_prev_r <= pin_lvl;
            if (pdiv_code_r == 3'H0) begin
                pdiv_out <= pin_lvl;
            end else if (pin_edge) begin
                pcnt_r <= pcnt_nxt;
                pdiv_out <= pcnt_nxt[pdiv_code_r - 3'H1];
            end
        end
    end

    // ==========================================
    // Glitchless switch
    csdr_sw_t sw_st_r; // Switch sequencer state.
    logic sw_cur_r; // Input now passed.
    logic sw_en_r; // Current input enabled.
    wire in0 = pdiv_out;
    wire in1 = src_v[feed_b_r];
    wire cur_lvl = sw_cur_r ? in1 : in0;
    wire new_lvl = sw_cur_r ? in0 : in1;

    // Drop the old input while it is low, then take the new one while
    // it is low; a stopped input stalls the sequence, hence both run.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sw_st_r <= SW_IDLE;
            sw_cur_r <= 1'b0;
            sw_en_r <= 1'b1;
            sw_out_r <= 1'b0;
        end else begin
            sw_out_r <= sw_en_r & cur_lvl;
            case (sw_st_r)
                SW_IDLE: begin
                    if (sw_want_r != sw_cur_r) begin
                        sw_st_r <= SW_DROP;
                    end
                end
                SW_DROP: begin
                    if (!cur_lvl) begin
                        sw_en_r <= 1'b0;
                        sw_st_r <= SW_PICK;
                    end
                end
                SW_PICK: begin
                    if (!new_lvl) begin
                        sw_cur_r <= ~sw_cur_r;
                        sw_en_r <= 1'b1;
                        sw_st_r <= SW_IDLE;
                    end
                end
                default: begin
                    sw_st_r <= SW_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Center selector and trunk gates
    logic [N_TRUNK-1:0] gate_eff_r; // Enables as applied to the trunks.

    // Each enable changes only while its source is low, so a trunk never
    // sees a runt; the gate sits in the same flop, adding no latency.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gate_eff_r <= '0;
            trunk <= '0;
        end else begin
            for (int i = 0; i < N_TRUNK; i++) begin
                if (!src_v[tsel_r[i]]) begin
                    gate_eff_r[i] <= tgate_r[i];
                end
                trunk[i] <= src_v[tsel_r[i]] & gate_eff_r[i];
            end
        end
    end

    // ==========================================
    // APB read and answer
    wire [31:0] rd_out = {15'H0, out_edge_r[oidx], 1'b0, out_ph_r[oidx],
        1'b0, out_lim_r[oidx]};
    wire [31:0] rd_stat = {gate_eff_r, 13'H0, sw_st_r != SW_IDLE,
        sw_cur_r, synth_lock};
    wire [31:0] rd_mux =
        (paddr == OFS_CTRL) ? {28'H0, ctrl_r} :
        (paddr == OFS_SYNTH) ? {17'H0, fb_lim_r, 1'b0, ref_lim_r} :
        (is_out && oidx < 3'(N_OUT)) ? rd_out :
        (paddr == OFS_PDIV) ? {7'H0, sw_want_r, 2'H0, feed_b_r, 2'H0,
            feed_a_r, 5'H0, pdiv_code_r} :
        (paddr == OFS_EDIV) ? {24'H0, esrc_r, 2'H0, emode_r} :
        (paddr == OFS_ENET) ? {16'H0, enet_sel_r[3], enet_sel_r[2],
            enet_sel_r[1], enet_sel_r[0]} :
        (paddr == OFS_TSEL) ? {20'H0, tidx_r, 2'H0, tsel_r[tidx_r]} :
        (paddr == OFS_TGATE) ? {16'H0, tgate_r} :
        (paddr == OFS_STAT) ? rd_stat : 32'H0;
    wire bad = !hit || (is_out && oidx >= 3'(N_OUT));

    // Zero wait states: the answer stands in the first access cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'H0;
        end else begin
            pready <= acc;
            pslverr <= acc & bad;
            prdata <= (acc && !pwrite) ? rd_mux : 32'H0;
        end
    end
endmodule

/* dv/csdr_assertions.sv */
/*
 Checker for the top ports of the clock block.
 Assumes APB on ref_clk and a synchronous, active-low rstn.
*/
`timescale 1ns/1ps
module csdr_assertions (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Clock outputs.
    input wire logic synth_lock,
    input wire logic pdiv_out,
    input wire logic ediv_out,
    input wire logic [csdr_pkg::N_TRUNK-1:0] trunk
);
    import csdr_pkg::*;
    // ==========================================
    // Shadow registers
    logic wr_setup; // A write lands on its ready edge.
    logic [3:0] ctrl_r; // Shadow of the control word.
    logic [15:0] gate_r; // Shadow of the trunk enables.
    assign wr_setup = psel && penable && pready && pwrite;
    // The shadows follow the slave so the port checks need no internal probe.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_r <= RST_CTRL;
            gate_r <= 16'H0000;
        end else if (wr_setup && paddr == OFS_CTRL) begin
            ctrl_r <= pwdata[3:0];
        end else if (wr_setup && paddr == OFS_TGATE) begin
            gate_r <= pwdata[15:0];
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_pdiv_rst; ctrl_r[2] |-> !pdiv_out; endproperty
    a_pdiv_rst: assert property (p_pdiv_rst) else $error("primary divider ran in reset");
    property p_ediv_rst; ctrl_r[3] |-> !ediv_out; endproperty
    a_ediv_rst: assert property (p_ediv_rst) else $error("edge divider ran in reset");
    property p_lock_drop; wr_setup && paddr[1:0] == 2'H0 && paddr <= OFS_OUTD5 |->
        ##[1:3] !synth_lock; endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock kept after retune");
    property p_lock_off; (!ctrl_r[0]) [*2] |-> !synth_lock; endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock while synth off");
    property p_gate_static; (gate_r == 16'H0000) [*8] |-> trunk == 16'H0000; endproperty
    a_gate_static: assert property (p_gate_static) else $error("gated trunk toggled");
    property p_rdy_setup; psel && !penable |=> pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
    property p_err_rdy; pslverr |-> pready && $past(psel); endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    property p_rdata_idle; !pready |-> prdata == 32'H0000_0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready");
endmodule
bind csdr_top csdr_assertions u_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .synth_lock(synth_lock), .pdiv_out(pdiv_out),
    .ediv_out(ediv_out), .trunk(trunk));

/* dv/csdr_fabric_model.sv */
/*
 Fabric and pin clock model facing the clock block.
 Assumes ref_clk; all clocks here are levels that change just after its edge.
*/
`timescale 1ns/1ps
module csdr_fabric_model (
    // Clock and step request.
    input wire logic ref_clk,
    input wire logic step,
    // Pin and fabric clocks.
    output logic pin_clk,
    output logic pin_clk_dly,
    output logic int_node,
    output logic fb_route,
    output logic [csdr_pkg::N_FAB-1:0] fabric_clk,
    output csdr_pkg::csdr_phase_ctl_t phase_ctl
);
    import csdr_pkg::*;
    // ==========================================
    // Free-running sources
    logic [7:0] cnt_r = 8'H00; // Base of every clock here.
    logic [3:0] ph_r = 4'H0; // Phase step sequencer.
    // Clocks never stop, so the glitchless switch can always finish.
    always_ff @(posedge ref_clk) begin
        cnt_r <= cnt_r + 8'H01;
        ph_r <= (step || ph_r != 4'H0) ? ph_r + 4'H1 : 4'H0;
    end
    assign pin_clk = cnt_r[1];
    // A period of four cycles makes one cycle of lag a quarter period.
    assign pin_clk_dly = ~cnt_r[1] ^ cnt_r[0];
    assign int_node = cnt_r[3];
    assign fb_route = cnt_r[2];
    assign fabric_clk = {28{cnt_r[2:1]}};
    // Rotate is high for eight cycles and low before the next step; load pulses in its last high cycle.
    assign phase_ctl = '{3'H0, cnt_r[7], ph_r[3], ph_r == 4'HF};
endmodule

/* dv/csdr_top_tb.sv */
/*
 Self-checking bench for the clock block.
 Assumes the fabric model supplies every clock level and phase control.
*/
`timescale 1ns/1ps
module csdr_top_tb;
    import csdr_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; int sel; int exp;} csdr_row_t;
    logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, step = 1'b0;
    logic [7:0] paddr = 8'H00;
    logic [31:0] pwdata = 32'H0, prdata, rd;
    logic pready, pslverr, er, pin_clk, pin_clk_dly, int_node, fb_route, synth_lock;
    logic pdiv_out, ediv_out;
    logic [N_FAB-1:0] fabric_clk;
    logic [N_OUT-1:0] synth_out;
    logic [N_ENET-1:0] edge_net;
    logic [N_TRUNK-1:0] trunk;
    csdr_phase_ctl_t phase_ctl;
    int err_count = 0, samples_checked = 0, cnt;
    // Select 0 primary, 1 edge, 2 synth out 0, 3 trunk 0, 4 edge net 0, 5 write only.
    csdr_row_t rows[20] = '{'{OFS_CTRL, 32'H5, 0, 0}, '{OFS_CTRL, 32'H1, 5, 0},
        '{OFS_PDIV, 32'H800, 0, 280}, '{OFS_PDIV, 32'H801, 0, 140},
        '{OFS_PDIV, 32'H802, 0, 70}, '{OFS_PDIV, 32'H803, 0, 35}, '{OFS_PDIV, 32'H804, 0, 17},
        '{OFS_PDIV, 32'H805, 0, 9}, '{OFS_PDIV, 32'H806, 0, 4}, '{OFS_PDIV, 32'H807, 0, 2},
        '{OFS_EDIV, 32'H0, 1, 140}, '{OFS_EDIV, 32'H1, 1, 80}, '{OFS_EDIV, 32'H2, 1, 70},
        '{OFS_EDIV, 32'H3, 1, 56}, '{OFS_OUTD0, 32'H1, 2, 560}, '{OFS_OUTD0, 32'H7F, 2, 9},
        '{OFS_TSEL, 32'H8, 3, 0}, '{OFS_TGATE, 32'H1, 3, 280}, '{OFS_TGATE, 32'H0, 3, 0},
        '{OFS_ENET, 32'H0, 4, 280}};
    // ==========================================
    // Clock, design and far side
    always #20 ref_clk = ~ref_clk;
    csdr_top dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_ctl(phase_ctl), .pin_clk(pin_clk), .pin_clk_dly(pin_clk_dly),
        .int_node(int_node), .fb_route(fb_route), .fabric_clk(fabric_clk),
        .synth_out(synth_out), .synth_lock(synth_lock), .pdiv_out(pdiv_out),
        .ediv_out(ediv_out), .edge_net(edge_net), .trunk(trunk));
    csdr_fabric_model u_fab (.ref_clk(ref_clk), .step(step), .pin_clk(pin_clk),
        .pin_clk_dly(pin_clk_dly), .int_node(int_node), .fb_route(fb_route),
        .fabric_clk(fabric_clk), .phase_ctl(phase_ctl));
    // ==========================================
    // Tasks
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    // Counts allow one edge of slack for the unknown start phase.
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got < exp - 1 || got > exp + 1) begin
            err_count++;
            $display("unexpected at %0t: %0d rises, wanted %0d", $time, got, exp);
        end
    endtask
    // One APB transfer; entered just after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic count(input int sel, output int c);
        logic prev, cur;
        prev = 1'b1;
        c = 0;
        repeat (1120) begin
            @(posedge ref_clk);
            cur = sel == 0 ? pdiv_out : sel == 1 ? ediv_out : sel == 2 ? synth_out[0] :
                sel == 3 ? trunk[0] : edge_net[0];
            if (cur === 1'b1 && prev === 1'b0) begin
                c++;
            end
            prev = cur;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        chk_val({pdiv_out, ediv_out, synth_lock, trunk}, 32'H0);
        rstn <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            if (rows[i].sel < 5) begin
                repeat (16) @(posedge ref_clk);
                count(rows[i].sel, cnt);
                chk_cnt(cnt, rows[i].exp);
            end
        end
        apb(1'b1, OFS_SYNTH, 32'H1);
        apb(1'b1, OFS_OUTD0, 32'H1);
        repeat (40) begin
            apb(1'b0, OFS_STAT, 32'H0);
        end
        chk_val({31'H0, rd[0]}, 32'H1);
        apb(1'b1, OFS_OUTD0, 32'H0);
        apb(1'b0, OFS_STAT, 32'H0);
        chk_val({31'H0, rd[0]}, 32'H0);
        step <= 1'b1;
        @(posedge ref_clk);
        step <= 1'b0;
        repeat (24) @(posedge ref_clk);
        apb(1'b0, 8'H3C, 32'H0);
        chk_val({31'H0, er}, 32'H1);
        chk_val(rd, 32'H0);
        apb(1'b0, OFS_PDIV, 32'H0);
        chk_val(rd, 32'H807);
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
